// ### verilog/commutation_pkg.sv
// commutation_pkg: shared types and constants for the six-step sequencer
// assumes a single 250 MHz system clock; no software registers
package commutation_pkg;

  localparam int unsigned CLK_MHZ         = 250;
  // off-time of the current-limit one-shot, in microseconds
  localparam int unsigned OFF_TIME_US     = 20;
  localparam int unsigned OFF_TIME_CYCLES = OFF_TIME_US * CLK_MHZ;
  // align and ramp durations in microseconds
  localparam int unsigned ALIGN_TIME_US   = 100000;
  localparam int unsigned RAMP_TIME_US    = 500000;
  localparam int unsigned ALIGN_CYCLES    = ALIGN_TIME_US * CLK_MHZ;
  localparam int unsigned RAMP_CYCLES     = RAMP_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W           = 32;

  typedef enum logic [6:0] {
    ST_ALIGN = 7'h01,
    ST_A     = 7'h02,
    ST_B     = 7'h04,
    ST_C     = 7'h08,
    ST_D     = 7'h10,
    ST_E     = 7'h20,
    ST_F     = 7'h40
  } comm_state_t;

  typedef enum logic [2:0] {
    MODE_ALIGN = 3'h1,
    MODE_RAMP  = 3'h2,
    MODE_RUN   = 3'h4
  } start_mode_t;

  // low side active high, high side active low
  typedef struct packed {
    logic low_a;
    logic low_b;
    logic low_c;
    logic high_a_n;
    logic high_b_n;
    logic high_c_n;
  } gate_drive_t;

  // one-hot selection of the phase the back-emf sampler watches
  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic phase_c;
  } sense_select_t;

  localparam gate_drive_t GATES_OFF  = 6'h07;
  localparam sense_select_t SENSE_NONE = 3'h0;

endpackage

// ### verilog/limit_one_shot.sv
// limit_one_shot: fixed off-time one-shot for the current limit
// assumes i_trip is already synchronous to i_clk
`timescale 1ns/10ps
`default_nettype none
module limit_one_shot
  import commutation_pkg::*;
#(
  parameter int unsigned OFF_CYCLES = OFF_TIME_CYCLES
)(
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_trip,
  output var  logic o_active
);

  logic [CNT_W-1:0] remaining;

  // a trip while counting is ignored; retrigger only after expiry
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      remaining <= '0;
      o_active  <= 1'b0;
    end
    else if (!o_active)
    begin
      if (i_trip) // R03
      begin
        remaining <= CNT_W'(OFF_CYCLES - 1); // R18
        o_active  <= 1'b1;
      end
    end
    else if (remaining == '0)
      o_active <= 1'b0; // R17
    else
      remaining <= remaining - 1'b1;
  end

endmodule
`default_nettype wire

// ### verilog/bldc_commutation_sequencer.sv
// bldc_commutation_sequencer: six-step commutation, start-up modes and gate drive
// assumes analog comparators deliver the trip, pwm, speed clock and undervoltage
// as logic levels from outside this clock domain; the bridge adds no dead time
//
// Contract
// R01 - three low-side gate outputs, one per phase, active high
// R02 - three high-side gate outputs, one per phase, active low
// R03 - current trip starts one-shot forcing all low sides off for off-time
// R04 - off-time should not exceed one pwm period, e.g. 25kHz
// R05 - each state drives one low side and one high side of different phases
// R06 - six states in fixed order form one full commutation cycle
// R07 - state machine advances once per speed oscillator clock cycle
// R08 - states A..F drive fixed low/high pairs, all others off
// R09 - undriven phase is routed to back-emf sampler per state
// R10 - speed oscillator clock is given out as tachometer signal
// R11 - gates combine state decode, pwm duty and current-limit gating
// R12 - undervoltage holds all six gates off
// R13 - reset enters align: low_b, high_a, high_c on, nothing sampled
// R14 - after align, ramp steps A..F with sampling off until timer ends
// R15 - after ramp, run mode enables back-emf sensing
// R16 - pwm applies only to low sides, gated with the one-shot
// R17 - after off-time, low sides follow decode again; retrip only after expiry
// R18 - off-time is a configurable system clock cycle count
`timescale 1ns/10ps
`default_nettype none
module bldc_commutation_sequencer
  import commutation_pkg::*;
#(
  parameter int unsigned OFF_CYCLES   = OFF_TIME_CYCLES,
  parameter int unsigned ALIGN_CNT    = ALIGN_CYCLES,
  parameter int unsigned RAMP_CNT     = RAMP_CYCLES
)(
  input  wire logic    i_clk,
  input  wire logic    i_reset,
  input  wire logic    i_current_trip,
  input  wire logic    i_pwm_duty,
  input  wire logic    i_speed_clock,
  input  wire logic    i_undervoltage,
  output var  logic    o_low_drive_a,
  output var  logic    o_low_drive_b,
  output var  logic    o_low_drive_c,
  output var  logic    o_high_drive_a_n,
  output var  logic    o_high_drive_b_n,
  output var  logic    o_high_drive_c_n,
  output var  logic    o_phase_a_sense,
  output var  logic    o_phase_b_sense,
  output var  logic    o_phase_c_sense,
  output var  logic    o_sense_enable,
  output var  logic    o_speed_clock_out,
  output var  logic    o_limit_active,
  output var  logic [2:0] o_mode
);

  // two-stage synchronisers; stage one feeds stage two only
  logic [3:0] sync_1;
  logic [3:0] sync_2;
  logic       speed_prev;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sync_1 <= 4'h0;
      sync_2 <= 4'h0;
    end
    else
    begin
      sync_1 <= {i_current_trip, i_pwm_duty, i_speed_clock, i_undervoltage};
      sync_2 <= sync_1;
    end
  end

  logic trip_s;
  logic pwm_s;
  logic speed_s;
  logic uv_s;
  assign trip_s  = sync_2[3];
  assign pwm_s   = sync_2[2];
  assign speed_s = sync_2[1];
  assign uv_s    = sync_2[0];

  logic speed_rise;
  assign speed_rise = speed_s && !speed_prev;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      speed_prev <= 1'b0;
    else
      speed_prev <= speed_s;
  end

  logic limit_active;

  limit_one_shot #(
    .OFF_CYCLES (OFF_CYCLES)
  ) u_one_shot (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_trip   (trip_s),
    .o_active (limit_active)
  );

  // start-up mode sequencing with align and ramp timers
  start_mode_t      mode;
  logic [CNT_W-1:0] mode_timer;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      mode       <= MODE_ALIGN; // R13
      mode_timer <= '0;
    end
    else
    begin
      case (mode)
        MODE_ALIGN:
        begin
          if (mode_timer == CNT_W'(ALIGN_CNT - 1))
          begin
            mode       <= MODE_RAMP; // R14
            mode_timer <= '0;
          end
          else
            mode_timer <= mode_timer + 1'b1;
        end
        MODE_RAMP:
        begin
          if (mode_timer == CNT_W'(RAMP_CNT - 1))
          begin
            mode       <= MODE_RUN; // R15
            mode_timer <= '0;
          end
          else
            mode_timer <= mode_timer + 1'b1;
        end
        MODE_RUN:
          mode <= MODE_RUN;
        default:
          mode <= MODE_ALIGN;
      endcase
    end
  end

  // commutation states; align holds through align mode and until the first speed clock rise in ramp
  comm_state_t state;
  comm_state_t next_state;

  always_comb
  begin
    case (state)
      ST_ALIGN: next_state = ST_A;
      ST_A:     next_state = ST_B; // R06
      ST_B:     next_state = ST_C;
      ST_C:     next_state = ST_D;
      ST_D:     next_state = ST_E;
      ST_E:     next_state = ST_F;
      ST_F:     next_state = ST_A;
      default:  next_state = ST_ALIGN;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      state <= ST_ALIGN; // R13
    else if (mode == MODE_ALIGN)
      state <= ST_ALIGN;
    else if (speed_rise)
      state <= next_state; // R07
  end

  // decode a state into unqualified gate requests (low active high, high active low)
  function automatic gate_drive_t decode_gates(input comm_state_t s);
    gate_drive_t g;
    g = GATES_OFF;
    case (s)
      ST_ALIGN: begin g.low_b = 1'b1; g.high_a_n = 1'b0; g.high_c_n = 1'b0; end // R13
      ST_A:     begin g.low_c = 1'b1; g.high_a_n = 1'b0; end // R08 R05
      ST_B:     begin g.low_c = 1'b1; g.high_b_n = 1'b0; end // R08 R05
      ST_C:     begin g.low_a = 1'b1; g.high_b_n = 1'b0; end // R08 R05
      ST_D:     begin g.low_a = 1'b1; g.high_c_n = 1'b0; end // R08 R05
      ST_E:     begin g.low_b = 1'b1; g.high_c_n = 1'b0; end // R08 R05
      ST_F:     begin g.low_b = 1'b1; g.high_a_n = 1'b0; end // R08 R05
      default:  g = GATES_OFF;
    endcase
    return g;
  endfunction

  function automatic sense_select_t decode_sense(input comm_state_t s);
    sense_select_t m;
    m = SENSE_NONE;
    case (s)
      ST_A, ST_D: m.phase_b = 1'b1; // R09
      ST_B, ST_E: m.phase_a = 1'b1; // R09
      ST_C, ST_F: m.phase_c = 1'b1; // R09
      default:    m = SENSE_NONE;
    endcase
    return m;
  endfunction

  gate_drive_t   decoded;
  gate_drive_t   next_gates;
  sense_select_t sense_sel;
  logic          low_allow;

  assign decoded   = decode_gates(state);
  assign sense_sel = decode_sense(state);
  // pwm and the one-shot gate the low sides only
  assign low_allow = pwm_s && !limit_active; // R16 R11 R03

  always_comb
  begin
    next_gates = decoded;
    next_gates.low_a = decoded.low_a && low_allow; // R11
    next_gates.low_b = decoded.low_b && low_allow;
    next_gates.low_c = decoded.low_c && low_allow;
    if (uv_s)
      next_gates = GATES_OFF; // R12
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_low_drive_a    <= 1'b0;
      o_low_drive_b    <= 1'b0;
      o_low_drive_c    <= 1'b0;
      o_high_drive_a_n <= 1'b1;
      o_high_drive_b_n <= 1'b1;
      o_high_drive_c_n <= 1'b1;
    end
    else
    begin
      o_low_drive_a    <= next_gates.low_a; // R01
      o_low_drive_b    <= next_gates.low_b;
      o_low_drive_c    <= next_gates.low_c;
      o_high_drive_a_n <= next_gates.high_a_n; // R02
      o_high_drive_b_n <= next_gates.high_b_n;
      o_high_drive_c_n <= next_gates.high_c_n;
    end
  end

  // sense selection is shown in states A..F, none in align; sampling only counts in run
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_phase_a_sense   <= 1'b0;
      o_phase_b_sense   <= 1'b0;
      o_phase_c_sense   <= 1'b0;
      o_sense_enable    <= 1'b0;
      o_speed_clock_out <= 1'b0;
      o_limit_active    <= 1'b0;
      o_mode            <= MODE_ALIGN;
    end
    else
    begin
      o_phase_a_sense   <= sense_sel.phase_a; // R09
      o_phase_b_sense   <= sense_sel.phase_b;
      o_phase_c_sense   <= sense_sel.phase_c;
      o_sense_enable    <= (mode == MODE_RUN); // R15 R14
      o_speed_clock_out <= speed_s; // R10
      o_limit_active    <= limit_active;
      o_mode            <= mode;
    end
  end

endmodule
`default_nettype wire

// ### verif/commutation_monitor.sv
// checker for the sequencer ports
// bound into every sequencer instance; sees ports only
`timescale 1ns/10ps
`default_nettype none
module commutation_monitor #(
  parameter int unsigned OFF_CYCLES = 20
)(
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_current_trip,
  input wire logic       i_pwm_duty,
  input wire logic       i_speed_clock,
  input wire logic       i_undervoltage,
  input wire logic       o_low_drive_a,
  input wire logic       o_low_drive_b,
  input wire logic       o_low_drive_c,
  input wire logic       o_high_drive_a_n,
  input wire logic       o_high_drive_b_n,
  input wire logic       o_high_drive_c_n,
  input wire logic       o_phase_a_sense,
  input wire logic       o_phase_b_sense,
  input wire logic       o_phase_c_sense,
  input wire logic       o_sense_enable,
  input wire logic       o_speed_clock_out,
  input wire logic       o_limit_active,
  input wire logic [2:0] o_mode
);
  logic [2:0]  lo, hi, sn;
  logic [31:0] run_len;
  assign lo = {o_low_drive_a, o_low_drive_b, o_low_drive_c};
  assign hi = ~{o_high_drive_a_n, o_high_drive_b_n, o_high_drive_c_n};
  assign sn = {o_phase_a_sense, o_phase_b_sense, o_phase_c_sense};
  // cycles the one-shot has been showing active
  always_ff @(posedge i_clk)
    if (i_reset || !o_limit_active) run_len <= '0;
    else run_len <= run_len + 32'h1;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence uv_held; i_undervoltage [*4]; endsequence
  sequence pwm_off; !i_pwm_duty [*4]; endsequence
  sequence tach_steady; $stable(i_speed_clock) [*4]; endsequence
  sequence trip_held; $rose(i_current_trip) ##0 i_current_trip [*3]; endsequence
  chk_uv_gates_off: assert property (uv_held |-> (lo | hi) == 3'h0)
    else $error("gate on in undervoltage");
  chk_pwm_lows_off: assert property (pwm_off |-> lo == 3'h0)
    else $error("low side on without pwm");
  chk_one_low: assert property ($onehot0(lo))
    else $error("two low sides on");
  chk_phase_differ: assert property ((lo & hi) == 3'h0)
    else $error("low and high of one phase on");
  chk_step_one_high: assert property (sn != 3'h0 |-> $onehot0(hi))
    else $error("two high sides on in a step");
  chk_sense_undriven: assert property ($onehot0(sn) && (sn & (lo | hi)) == 3'h0)
    else $error("sensed phase is driven");
  chk_align_quiet: assert property (o_mode == 3'h1 |-> sn == 3'h0 && !o_sense_enable)
    else $error("sampling in align");
  chk_enable_run: assert property (o_sense_enable == (o_mode == 3'h4))
    else $error("sense enable outside run");
  chk_limit_lows: assert property (o_limit_active |-> lo == 3'h0)
    else $error("low side on in off-time");
  // the one-shot counts OFF_CYCLES system clocks, so the flag stands exactly that long
  chk_limit_len: assert property ($fell(o_limit_active) |-> run_len == OFF_CYCLES)
    else $error("off-time length wrong");
  chk_trip_arms: assert property (trip_held |-> ##[1:3] o_limit_active)
    else $error("trip did not start off-time");
  chk_tach_follow: assert property (tach_steady |-> o_speed_clock_out == i_speed_clock)
    else $error("tach differs from speed clock");
endmodule
bind bldc_commutation_sequencer commutation_monitor #(
  .OFF_CYCLES (OFF_CYCLES)
) mon (
  .i_clk             (i_clk),
  .i_reset           (i_reset),
  .i_current_trip    (i_current_trip),
  .i_pwm_duty        (i_pwm_duty),
  .i_speed_clock     (i_speed_clock),
  .i_undervoltage    (i_undervoltage),
  .o_low_drive_a     (o_low_drive_a),
  .o_low_drive_b     (o_low_drive_b),
  .o_low_drive_c     (o_low_drive_c),
  .o_high_drive_a_n  (o_high_drive_a_n),
  .o_high_drive_b_n  (o_high_drive_b_n),
  .o_high_drive_c_n  (o_high_drive_c_n),
  .o_phase_a_sense   (o_phase_a_sense),
  .o_phase_b_sense   (o_phase_b_sense),
  .o_phase_c_sense   (o_phase_c_sense),
  .o_sense_enable    (o_sense_enable),
  .o_speed_clock_out (o_speed_clock_out),
  .o_limit_active    (o_limit_active),
  .o_mode            (o_mode)
);
`default_nettype wire

// ### verif/bridge_model.sv
// three-phase bridge: sense current flows through any conducting low side
// the bench decides when the load is heavy enough to trip the limit
`timescale 1ns/10ps
`default_nettype none
module bridge_model
  import commutation_pkg::*;
(
  input  wire logic        i_overload,
  input  wire gate_drive_t i_gates,
  output var  logic        o_trip,
  output var  logic        o_shoot
);
  // current dies as soon as the one-shot opens every low side
  assign o_trip = i_overload && (i_gates.low_a || i_gates.low_b || i_gates.low_c);
  assign o_shoot = (i_gates.low_a && !i_gates.high_a_n) || (i_gates.low_b && !i_gates.high_b_n)
                   || (i_gates.low_c && !i_gates.high_c_n);
endmodule
`default_nettype wire

// ### verif/bldc_commutation_sequencer_tb.sv
// self-checking bench for the commutation sequencer
// short align, ramp and off-time counts keep the run brief
`timescale 1ns/10ps
`default_nettype none
module bldc_commutation_sequencer_tb;
  import commutation_pkg::*;
  localparam int unsigned OFF_CYCLES = 20;
  // lows, highs_n, sense for align and steps A..F
  localparam logic [8:0] ST [7] = '{9'h090, 9'h05a, 9'h06c, 9'h129, 9'h132, 9'h0b4, 9'h099};
  logic i_clk, i_reset, i_current_trip, i_pwm_duty, i_speed_clock, i_undervoltage;
  logic o_low_drive_a, o_low_drive_b, o_low_drive_c, o_phase_a_sense, o_phase_b_sense;
  logic o_high_drive_a_n, o_high_drive_b_n, o_high_drive_c_n, o_phase_c_sense;
  logic o_sense_enable, o_speed_clock_out, o_limit_active, overload, shoot;
  logic [2:0]  o_mode;
  logic [7:0]  lfsr = 8'h49;
  logic [13:0] obs;
  logic [13:0] exp_q [$];
  gate_drive_t gates;
  int n_errors = 0;
  int num_checks = 0;
  int st = 0;
  event sample;
  assign gates = {o_low_drive_a, o_low_drive_b, o_low_drive_c,
                  o_high_drive_a_n, o_high_drive_b_n, o_high_drive_c_n};
  assign obs = {o_mode, o_sense_enable, o_limit_active, gates,
                o_phase_a_sense, o_phase_b_sense, o_phase_c_sense};
  bldc_commutation_sequencer #(
    .OFF_CYCLES (OFF_CYCLES),
    .ALIGN_CNT  (50),
    .RAMP_CNT   (200)
  ) uut (
    .i_clk             (i_clk),
    .i_reset           (i_reset),
    .i_current_trip    (i_current_trip),
    .i_pwm_duty        (i_pwm_duty),
    .i_speed_clock     (i_speed_clock),
    .i_undervoltage    (i_undervoltage),
    .o_low_drive_a     (o_low_drive_a),
    .o_low_drive_b     (o_low_drive_b),
    .o_low_drive_c     (o_low_drive_c),
    .o_high_drive_a_n  (o_high_drive_a_n),
    .o_high_drive_b_n  (o_high_drive_b_n),
    .o_high_drive_c_n  (o_high_drive_c_n),
    .o_phase_a_sense   (o_phase_a_sense),
    .o_phase_b_sense   (o_phase_b_sense),
    .o_phase_c_sense   (o_phase_c_sense),
    .o_sense_enable    (o_sense_enable),
    .o_speed_clock_out (o_speed_clock_out),
    .o_limit_active    (o_limit_active),
    .o_mode            (o_mode)
  );
  bridge_model bridge (.i_overload(overload), .i_gates(gates), .o_trip(i_current_trip),
                       .o_shoot(shoot));
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task tick(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task note(logic [2:0] m, logic lim, logic [8:0] p);
    exp_q.push_back({m, m == 3'h4, lim, p});
    -> sample;
  endtask
  // random low time on the speed clock, never shorter than the sync depth
  task pulse;
    i_speed_clock = 1'b1;
    tick(6);
    i_speed_clock = 1'b0;
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    tick(3 + int'(lfsr[1:0]));
  endtask
  task wait_mode(logic [2:0] m);
    for (int i = 0; i < 400 && o_mode !== m; i++) tick(1);
  endtask
  always @(sample)
  begin
    logic [13:0] e;
    e = exp_q.pop_front();
    num_checks++;
    if (obs !== e)
    begin
      n_errors++;
      $display("wrong value outputs expected %h seen %h", e, obs);
    end
  end
  always @(posedge i_clk)
    if (shoot !== 1'b0 && !i_reset)
    begin
      n_errors++;
      $display("wrong value shoot expected 0 seen %b", shoot);
    end
  initial
  begin
    i_reset = 1'b1;
    i_pwm_duty = 1'b1;
    i_speed_clock = 1'b0;
    i_undervoltage = 1'b0;
    overload = 1'b0;
    tick(12);
    i_reset = 1'b0;
    tick(4);
    note(3'h1, 1'b0, ST[0]);
    pulse;
    note(3'h1, 1'b0, ST[0]);
    wait_mode(3'h2);
    note(3'h2, 1'b0, ST[0]);
    for (int k = 0; k < 8; k++)
    begin
      pulse;
      st = st % 6 + 1;
      note(3'h2, 1'b0, ST[st]);
    end
    i_pwm_duty = 1'b0;
    tick(5);
    note(3'h2, 1'b0, ST[st] & 9'h03f);
    i_pwm_duty = 1'b1;
    tick(5);
    overload = 1'b1;
    tick(6);
    note(3'h2, 1'b1, ST[st] & 9'h03f);
    overload = 1'b0;
    tick(OFF_CYCLES + 4);
    note(3'h2, 1'b0, ST[st]);
    i_undervoltage = 1'b1;
    tick(5);
    note(3'h2, 1'b0, {6'h07, ST[st][2:0]});
    i_undervoltage = 1'b0;
    wait_mode(3'h4);
    note(3'h4, 1'b0, ST[st]);
    pulse;
    st = st % 6 + 1;
    note(3'h4, 1'b0, ST[st]);
    i_reset = 1'b1;
    tick(12);
    i_reset = 1'b0;
    tick(4);
    note(3'h1, 1'b0, ST[0]);
    end_sim;
  end
  initial
  begin
    #12000;
    n_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
